// *** common/sltm_pkg.sv ***
// Constants, register map and types for the safe lock opening timer.
// Assumes a 50 MHz clock and APB with 32-bit data.
package sltm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_PERIOD_NS = 1000000000;     // One second
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [16:0] SEC_PER_MIN = 17'h0003c;
    localparam logic [18:0] SEC_PER_HOUR = 19'h00e10;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_DURESS = 8'h08;
    localparam logic [7:0] ADDR_CONFIRM = 8'h0c;
    localparam logic [7:0] ADDR_NOREOPEN = 8'h10;
    localparam logic [7:0] ADDR_ALARM = 8'h14;
    localparam logic [7:0] ADDR_DUAL = 8'h18;
    localparam logic [7:0] ADDR_BOLT = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_AUTH = 8'h24;

    // ------------------------------------------------------------
    // Control bits and field positions
    // ------------------------------------------------------------
    localparam int CTRL_DUAL_BIT = 0;
    localparam int CTRL_COURIER_SKIP_BIT = 1;
    localparam int CTRL_ALARM_EN_BIT = 2;
    localparam int AUTH_RESULT_BIT = 16;
    localparam int STAT_REMAIN_LSB = 16;

    // ------------------------------------------------------------
    // Reset values and limits ({minutes,seconds} or {hours,minutes})
    // ------------------------------------------------------------
    localparam logic [6:0] DELAY_RST = 7'h00;
    localparam logic [6:0] DELAY_MAX = 7'h63;             // 99 minutes
    localparam logic [6:0] CONFIRM_RST = 7'h05;
    localparam logic [6:0] CONFIRM_MIN = 7'h01;
    localparam logic [6:0] CONFIRM_MAX = 7'h63;
    localparam logic [15:0] NOREOPEN_RST = 16'h0000;
    localparam logic [15:0] NOREOPEN_MAX = 16'h6300;       // 99:00 h
    localparam logic [15:0] ALARM_RST = 16'h0300;          // 3:00
    localparam logic [15:0] ALARM_MAX = 16'h6300;          // 99:00
    localparam logic [15:0] DUAL_RST = 16'h0100;           // 1:00
    localparam logic [15:0] DUAL_MIN = 16'h000f;           // 0:15
    localparam logic [15:0] DUAL_MAX = 16'h021e;           // 2:30
    localparam logic [15:0] BOLT_RST = 16'h0006;           // 0:06
    localparam logic [15:0] BOLT_MIN = 16'h0006;
    localparam logic [15:0] BOLT_MAX = 16'h6300;           // 99:00
    localparam logic [7:0] SEC_FIELD_MAX = 8'h3b;          // 59
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [2:0] CTRL_RST = 3'h0;                // Dual off, alarm off

    // ------------------------------------------------------------
    // Code classes, operations and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CL_MASTER  = 2'b00,
        CL_MANAGER = 2'b01,
        CL_USER    = 2'b10,
        CL_COURIER = 2'b11
    } sltm_class_t;

    typedef enum logic [1:0] {
        OP_ACTIVATE = 2'b00,
        OP_MODIFY   = 2'b01,
        OP_DELETE   = 2'b10,
        OP_NONE     = 2'b11
    } sltm_op_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DUAL    = 3'b001,
        ST_DELAY   = 3'b010,
        ST_CONFIRM = 3'b011,
        ST_OPEN    = 3'b100
    } sltm_state_t;

endpackage : sltm_pkg

// *** rtl/sltm_tick.sv ***
// One-second tick generator for all timers of the lock.
// Assumes a free-running clock at the rate set by the divide parameter.
`timescale 1ns/1ps
module sltm_tick
    import sltm_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Tick
    output logic      tick
);

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    logic [31:0] cnt_q;

    // Wraps at DIV-1 and pulses for one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (cnt_q == DIV - 1) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end

endmodule : sltm_tick

// *** rtl/sltm_top.sv ***
// Opening timer and code authority checker of an electronic safe lock.
// Assumes an APB master, a keypad unit that pulses code_valid per accepted
// code, and door/boltwork contacts synchronous to clk.
//
// Contract
// - Bolt stays locked until group delay expires
// - Group delay is 0 to 99 minutes
// - All group delays reset to zero
// - Four delay settings, one per group
// - Courier code opens with no delay
// - Per-group duress delay replaces normal delay
// - External suppress input skips the delay
// - Delay expiry opens confirm window, needs code
// - Confirm window defaults five, minimum one minute
// - Confirm window up to 99, never disabled
// - Courier skip option leads to confirm window
// - No reopen until no-reopen period elapsed
// - No-reopen period hours:minutes, up to 99h
// - Door-open alarm after limit, off, 3 min
// - Alarm limit minutes:seconds up to 99 min
// - Dual mode second code within window
// - Dual window limited to 0:15 to 2:30
// - Bolt relocks after bolt-open time, 6 s
// - Door or boltwork open holds relock
// - Bolt-open time 0:06 to 99:00
// - Code changes follow fixed authority matrix
`timescale 1ns/1ps
module sltm_top
    import sltm_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Keypad unit
    input  wire logic        code_valid,
    input  wire logic [1:0]  code_class,
    input  wire logic [1:0]  code_group,
    input  wire logic        code_duress,
    input  wire logic        delay_suppress,
    // Contacts
    input  wire logic        door_open,
    input  wire logic        bolt_held_open,
    // Lock outputs
    output logic             bolt_unlock,
    output logic             confirm_window,
    output logic             beeper,
    output logic             code_refused
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Limit the seconds field, then bound the packed pair; packed order
    // equals time order once seconds never exceed 59.
    function automatic logic [15:0] clamp_ms(input logic [15:0] v, input logic [15:0] lo,
                                             input logic [15:0] hi);
        logic [15:0] r;
        r = {v[15:8], (v[7:0] > SEC_FIELD_MAX) ? SEC_FIELD_MAX : v[7:0]};
        if (r < lo) r = lo;
        if (r > hi) r = hi;
        return r;
    endfunction : clamp_ms

    // Minutes:seconds to seconds
    function automatic logic [16:0] ms_to_sec(input logic [15:0] v);
        return 17'(v[15:8] * SEC_PER_MIN) + 17'(v[7:0]);
    endfunction : ms_to_sec

    // Authority matrix: actor class/group on target class/group
    function automatic logic auth_ok(input logic [1:0] ac, input logic [1:0] ag,
                                     input logic [1:0] tc, input logic [1:0] tg,
                                     input logic [1:0] op, input logic own);
        logic r;
        r = 1'b0;
        if (op == OP_NONE) r = 1'b0;
        else if (tc == CL_MASTER) r = (ac == CL_MASTER) && (op == OP_MODIFY);
        else if (ac == CL_MASTER) r = 1'b1;
        else if (tc == CL_USER && ac == CL_MANAGER && ag == tg) r = 1'b1;
        else r = (ac == tc) && (ag == tg) && own && (op == OP_MODIFY);
        return r;
    endfunction : auth_ok

    // ------------------------------------------------------------
    // One-second tick
    // ------------------------------------------------------------
    logic tick;

    sltm_tick #(
        .DIV  (TICK_DIV)
    ) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0]       ctrl_q;
    logic [6:0]       delay_q [4];
    logic [6:0]       duress_q [4];
    logic [6:0]       confirm_q;
    logic [15:0]      noreopen_q;
    logic [15:0]      alarm_q;
    logic [15:0]      dual_q;
    logic [15:0]      bolt_q;
    logic [10:0]      auth_q;
    logic             wr_en;
    logic             rd_setup;
    logic             mapped;
    logic [31:0]      rd_d;
    sltm_state_t      state_q;
    logic [16:0]      timer_q;
    logic [18:0]      nr_cnt_q;
    logic [16:0]      door_cnt_q;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign mapped = (paddr <= ADDR_AUTH) && (paddr[1:0] == 2'b00);
    assign pready = 1'b1;                         // No wait states
    assign pslverr = psel && penable && !mapped;

    // Settings: out-of-range writes are bounded, so no illegal value stands
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q     <= CTRL_RST;
            confirm_q  <= CONFIRM_RST;
            noreopen_q <= NOREOPEN_RST;
            alarm_q    <= ALARM_RST;
            dual_q     <= DUAL_RST;
            bolt_q     <= BOLT_RST;
            auth_q     <= 11'h000;
        end else if (wr_en) begin
            case (paddr)
                ADDR_CTRL: begin
                    ctrl_q <= pwdata[2:0];
                end
                ADDR_CONFIRM: begin
                    confirm_q <= (pwdata[6:0] < CONFIRM_MIN) ? CONFIRM_MIN :
                                 (pwdata[6:0] > CONFIRM_MAX) ? CONFIRM_MAX : pwdata[6:0];
                end
                ADDR_NOREOPEN: begin
                    noreopen_q <= (pwdata[15:0] > NOREOPEN_MAX) ? NOREOPEN_MAX :
                                  {pwdata[15:8], (pwdata[7:0] > SEC_FIELD_MAX) ? SEC_FIELD_MAX : pwdata[7:0]};
                end
                ADDR_ALARM: begin
                    alarm_q <= clamp_ms(pwdata[15:0], ZERO16, ALARM_MAX);
                end
                ADDR_DUAL: begin
                    dual_q <= clamp_ms(pwdata[15:0], DUAL_MIN, DUAL_MAX);
                end
                ADDR_BOLT: begin
                    bolt_q <= clamp_ms(pwdata[15:0], BOLT_MIN, BOLT_MAX);
                end
                ADDR_AUTH: begin
                    auth_q <= pwdata[10:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Four group delay and duress settings, one byte lane each
    for (genvar g = 0; g < 4; g++) begin : g_grp
        always_ff @(posedge clk) begin
            if (rst) begin
                delay_q[g]  <= DELAY_RST;
                duress_q[g] <= DELAY_RST;
            end else if (wr_en && paddr == ADDR_DELAY) begin
                delay_q[g] <= (pwdata[8*g +: 7] > DELAY_MAX) ? DELAY_MAX : pwdata[8*g +: 7];
            end else if (wr_en && paddr == ADDR_DURESS) begin
                duress_q[g] <= (pwdata[8*g +: 7] > DELAY_MAX) ? DELAY_MAX : pwdata[8*g +: 7];
            end
        end
    end

    // Read mux, captured in the setup phase so prdata is a flop
    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL:     rd_d = {29'h0, ctrl_q};
            ADDR_DELAY:    rd_d = {1'b0, delay_q[3], 1'b0, delay_q[2], 1'b0, delay_q[1], 1'b0, delay_q[0]};
            ADDR_DURESS:   rd_d = {1'b0, duress_q[3], 1'b0, duress_q[2], 1'b0, duress_q[1], 1'b0, duress_q[0]};
            ADDR_CONFIRM:  rd_d = {25'h0, confirm_q};
            ADDR_NOREOPEN: rd_d = {16'h0, noreopen_q};
            ADDR_ALARM:    rd_d = {16'h0, alarm_q};
            ADDR_DUAL:     rd_d = {16'h0, dual_q};
            ADDR_BOLT:     rd_d = {16'h0, bolt_q};
            ADDR_STATUS:   rd_d = {timer_q[STAT_REMAIN_LSB-1:0], 9'h0,
                                   nr_cnt_q != 19'h0, beeper, bolt_unlock, confirm_window, state_q};
            ADDR_AUTH:     rd_d = {15'h0,
                                   auth_ok(auth_q[1:0], auth_q[3:2], auth_q[5:4], auth_q[7:6],
                                           auth_q[9:8], auth_q[10]),
                                   5'h0, auth_q};
            default:       rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) prdata <= 32'h0000_0000;
        else if (rd_setup) prdata <= rd_d;
    end

    // ------------------------------------------------------------
    // Opening sequence
    // ------------------------------------------------------------
    logic        nr_block;
    logic        expired;
    logic        is_courier;
    logic [6:0]  grp_delay;
    logic [16:0] grp_delay_sec;
    logic [1:0]  first_class_q;
    logic [1:0]  first_group_q;
    logic        first_duress_q;
    logic [1:0]  use_class;
    logic [1:0]  use_group;
    logic        use_duress;

    assign nr_block = nr_cnt_q != 19'h0;
    assign expired = tick && (timer_q <= 17'h00001);
    // Decide on the pair's first code in dual mode
    assign use_class = (state_q == ST_DUAL) ? first_class_q : code_class;
    assign use_group = (state_q == ST_DUAL) ? first_group_q : code_group;
    assign use_duress = (state_q == ST_DUAL) ? first_duress_q : code_duress;
    assign is_courier = use_class == CL_COURIER;
    assign grp_delay = use_duress ? duress_q[use_group] : delay_q[use_group];
    assign grp_delay_sec = 17'(grp_delay * SEC_PER_MIN);

    // Main state machine; its state timer decrements on the shared tick
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q        <= ST_IDLE;
            timer_q        <= 17'h00000;
            first_class_q  <= CL_MASTER;
            first_group_q  <= 2'b00;
            first_duress_q <= 1'b0;
            code_refused   <= 1'b0;
        end else begin
            code_refused <= 1'b0;
            if (tick && timer_q != 17'h00000) timer_q <= timer_q - 17'h00001;
            case (state_q)
                ST_IDLE, ST_DUAL: begin
                    if (state_q == ST_DUAL && expired && !code_valid) begin
                        state_q <= ST_IDLE;
                    end else if (code_valid && nr_block) begin
                        code_refused <= 1'b1;
                    end else if (code_valid && state_q == ST_IDLE && ctrl_q[CTRL_DUAL_BIT]) begin
                        state_q        <= ST_DUAL;
                        timer_q        <= ms_to_sec(dual_q);
                        first_class_q  <= code_class;
                        first_group_q  <= code_group;
                        first_duress_q <= code_duress;
                    end else if (code_valid) begin
                        if (is_courier && ctrl_q[CTRL_COURIER_SKIP_BIT]) begin
                            state_q <= ST_CONFIRM;
                            timer_q <= 17'(confirm_q * SEC_PER_MIN);
                        end else if (is_courier || delay_suppress || grp_delay == DELAY_RST) begin
                            state_q <= ST_OPEN;
                            timer_q <= ms_to_sec(bolt_q);
                        end else begin
                            state_q <= ST_DELAY;
                            timer_q <= grp_delay_sec;
                        end
                    end
                end
                ST_DELAY: begin
                    if (expired) begin
                        state_q <= ST_CONFIRM;
                        timer_q <= 17'(confirm_q * SEC_PER_MIN);
                    end
                end
                ST_CONFIRM: begin
                    if (code_valid) begin
                        state_q <= ST_OPEN;
                        timer_q <= ms_to_sec(bolt_q);
                    end else if (expired) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_OPEN: begin
                    if ((timer_q == 17'h00000 || expired) && !door_open && !bolt_held_open) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Bolt and window outputs from the state register
    assign bolt_unlock = state_q == ST_OPEN;
    assign confirm_window = state_q == ST_CONFIRM;

    // ------------------------------------------------------------
    // No-reopen and door alarm timers
    // ------------------------------------------------------------
    logic closing;

    assign closing = (state_q == ST_OPEN) && (timer_q == 17'h00000 || expired) && !door_open
                     && !bolt_held_open;

    // Loaded on relock; a zero setting leaves it idle
    always_ff @(posedge clk) begin
        if (rst) begin
            nr_cnt_q <= 19'h00000;
        end else if (closing) begin
            nr_cnt_q <= 19'(noreopen_q[15:8] * SEC_PER_HOUR) + 19'(noreopen_q[7:0] * SEC_PER_MIN);
        end else if (tick && nr_block) begin
            nr_cnt_q <= nr_cnt_q - 19'h00001;
        end
    end

    // Counts open-door seconds; saturates so the beeper stays on
    always_ff @(posedge clk) begin
        if (rst) begin
            door_cnt_q <= 17'h00000;
            beeper     <= 1'b0;
        end else if (!door_open) begin
            door_cnt_q <= 17'h00000;
            beeper     <= 1'b0;
        end else begin
            if (tick && door_cnt_q < ms_to_sec(alarm_q)) door_cnt_q <= door_cnt_q + 17'h00001;
            beeper <= ctrl_q[CTRL_ALARM_EN_BIT] && door_cnt_q >= ms_to_sec(alarm_q);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_DELAY_HOLDS: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_DELAY |-> !bolt_unlock) else $error("bolt open during delay");
    AST_DELAY_RANGE: assert property (@(posedge clk) disable iff (rst)
        delay_q[0] <= DELAY_MAX && duress_q[3] <= DELAY_MAX) else $error("delay out of range");
    AST_DELAY_TO_CONFIRM: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_DELAY && expired |=> confirm_window && !bolt_unlock)
        else $error("delay expiry did not open confirm window");
    AST_CONFIRM_MIN: assert property (@(posedge clk) disable iff (rst)
        confirm_q >= CONFIRM_MIN && confirm_q <= CONFIRM_MAX) else $error("confirm window out of range");
    AST_COURIER_OPEN: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && code_valid && !nr_block && code_class == CL_COURIER
        && !ctrl_q[CTRL_DUAL_BIT] && !ctrl_q[CTRL_COURIER_SKIP_BIT] |=> bolt_unlock)
        else $error("courier code did not open");
    AST_SUPPRESS: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && code_valid && !nr_block && delay_suppress && !ctrl_q[CTRL_DUAL_BIT]
        && code_class != CL_COURIER |=> bolt_unlock) else $error("suppress input ignored");
    AST_NO_REOPEN: assert property (@(posedge clk) disable iff (rst)
        code_valid && nr_block && state_q == ST_IDLE |=> code_refused && !bolt_unlock)
        else $error("opening during no-reopen period");
    AST_DUAL_RANGE: assert property (@(posedge clk) disable iff (rst)
        dual_q >= DUAL_MIN && dual_q <= DUAL_MAX) else $error("dual window out of range");
    AST_HOLD_OPEN: assert property (@(posedge clk) disable iff (rst)
        bolt_unlock && door_open |=> bolt_unlock) else $error("relock with door open");
    AST_BOLT_RANGE: assert property (@(posedge clk) disable iff (rst)
        bolt_q >= BOLT_MIN && bolt_q <= BOLT_MAX) else $error("bolt time out of range");
    AST_ALARM_OFF: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[CTRL_ALARM_EN_BIT] |=> !beeper) else $error("beeper while alarm disabled");
    AST_AUTH_MASTER: assert property (@(posedge clk) disable iff (rst)
        auth_q[5:4] == CL_MASTER && auth_q[9:8] == OP_DELETE |-> !rd_d[AUTH_RESULT_BIT] || paddr != ADDR_AUTH)
        else $error("master code deletable");

endmodule : sltm_top

// *** dv/sltm_keypad.sv ***
// Keypad unit model: presents one accepted code per call of send.
// Assumes the caller enters send just after a rising edge of clk.
`timescale 1ns/1ps
module sltm_keypad (
    // Clock
    input  wire logic clk,
    // Code link
    output logic       code_valid,
    output logic [1:0] code_class,
    output logic [1:0] code_group,
    output logic       code_duress
);
    // One-cycle pulse; fields are inverted after it so stale values are never trusted
    task automatic send(input logic [1:0] c, input logic [1:0] g, input logic d);
        code_class <= c;
        code_group <= g;
        code_duress <= d;
        code_valid <= 1'b1;
        @(posedge clk);
        code_valid <= 1'b0;
        code_class <= ~c;
        code_group <= ~g;
        code_duress <= ~d;
    endtask : send
    // Idle link at time zero
    initial begin
        code_valid = 1'b0;
    end
endmodule : sltm_keypad

// *** dv/safe_lock_opening_timer_bench.sv ***
// Self-checking bench for the safe lock opening timer.
// Assumes the tick is cut to 10 clocks, so one minute is 600 cycles.
`timescale 1ns/1ps
module safe_lock_opening_timer_bench
    import sltm_pkg::*;
();
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic delay_suppress = 1'b0, door_open = 1'b0, bolt_held_open = 1'b0;
    logic code_valid, code_duress, pready, pslverr, bolt_unlock, confirm_window, beeper, code_refused;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic [1:0] code_class, code_group, g;
    logic [7:0] ta[9] = '{ADDR_DELAY, ADDR_DURESS, ADDR_NOREOPEN, ADDR_ALARM, ADDR_DUAL, ADDR_BOLT,
                         ADDR_CONFIRM, ADDR_NOREOPEN, ADDR_CONFIRM};
    logic [31:0] tw[9] = '{0, 0, 32'h6400, 32'h6400, 32'h0300, 0, 32'h64, 0, 0};
    logic [31:0] tr[9] = '{0, 0, 32'h6300, 32'h6300, 32'h021e, 6, 32'h63, 0, 1};
    int err_total = 0, n_checks = 0, seed = 83663, t;
    wire [2:0] outs = {beeper, confirm_window, bolt_unlock};
    always #10 clk = ~clk;
    sltm_top #(.TICK_DIV(10)) i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .code_valid, .code_class, .code_group, .code_duress, .delay_suppress,
        .door_open, .bolt_held_open, .bolt_unlock, .confirm_window, .beeper, .code_refused);
    sltm_keypad i_kp (.clk, .code_valid, .code_class, .code_group, .code_duress);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // APB transfer; request held until pready is seen at an edge, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Code entry; one more edge so the reaction to the taken code is visible
    task automatic kp(input logic [1:0] c, input logic [1:0] gg, input logic d);
        i_kp.send(c, gg, d);
        @(posedge clk);
    endtask : kp
    // Bounded wait for one lock output to reach a level, then compare it
    task automatic wt(input int k, input logic lvl, input int lim);
        for (t = 0; outs[k] !== lvl && t < lim; t++) @(posedge clk);
        chk({31'h0, outs[k]}, {31'h0, lvl});
    endtask : wt
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // Watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ta[i]) begin
            apb(1'b0, ta[i], 32'h0);
            t = (i < 3) ? 0 : (i == 3) ? 32'h300 : (i == 4) ? 32'h100 : (i == 5) ? 6 : 5;
            chk(v, t);
            if (i > 5) chk(v, 32'h5);
            if (i > 5) break;
        end
        foreach (ta[i]) begin
            apb(1'b1, ta[i], tw[i]);
            apb(1'b0, ta[i], 32'h0);
            chk(v, tr[i]);
        end
        apb(1'b0, 8'h28, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(v, 32'h0);
        $display("test registers done");
        g = 2'($random(seed));
        apb(1'b1, ADDR_CTRL, 32'h4);
        apb(1'b1, ADDR_ALARM, 32'h1);
        kp(2'h2, g, 1'b0);
        chk(outs, 3'h1);
        door_open <= 1'b1;
        wt(2, 1'b1, 40);
        repeat (100) @(posedge clk);
        chk(outs[0], 1'b1);
        door_open <= 1'b0;
        wt(0, 1'b0, 80);
        // One minute stays far below any weekly locking gap
        apb(1'b1, ADDR_DELAY, 32'h01010101);
        kp(2'h1, g, 1'b0);
        repeat (500) @(posedge clk);
        chk(outs, 3'h0);
        wt(1, 1'b1, 200);
        kp(2'h2, g, 1'b0);
        chk(outs[1:0], 2'h1);
        wt(0, 1'b0, 80);
        kp(2'h0, 2'h0, 1'b1);
        chk(outs[0], 1'b1);
        wt(0, 1'b0, 80);
        delay_suppress <= 1'b1;
        kp(2'h2, g, 1'b0);
        chk(outs[0], 1'b1);
        delay_suppress <= 1'b0;
        wt(0, 1'b0, 80);
        kp(2'h3, g, 1'b0);
        chk(outs[0], 1'b1);
        wt(0, 1'b0, 80);
        apb(1'b1, ADDR_CTRL, 32'h2);
        kp(2'h3, g, 1'b0);
        chk(outs[1:0], 2'h2);
        wt(1, 1'b0, 700);
        chk(outs[0], 1'b0);
        apb(1'b1, ADDR_AUTH, 32'h500);
        apb(1'b0, ADDR_AUTH, 32'h0);
        chk(v[16], 1'b1);
        apb(1'b1, ADDR_AUTH, 32'h202);
        apb(1'b0, ADDR_AUTH, 32'h0);
        chk(v[16], 1'b0);
        // Dual mode: a pair inside the window opens, a lone code is dropped
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_DELAY, 32'h0);
        apb(1'b1, ADDR_DUAL, 32'hf);
        kp(2'h2, g, 1'b0);
        chk(outs, 3'h0);
        kp(2'h2, g, 1'b0);
        chk(outs[0], 1'b1);
        wt(0, 1'b0, 80);
        kp(2'h2, g, 1'b0);
        repeat (200) @(posedge clk);
        kp(2'h2, g, 1'b0);
        chk(outs[0], 1'b0);
        // No-reopen: the relock starts the period, the next code is refused
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_NOREOPEN, 32'h1);
        kp(2'h3, g, 1'b0);
        chk(outs[0], 1'b1);
        wt(0, 1'b0, 80);
        kp(2'h2, g, 1'b0);
        chk({code_refused, outs[0]}, 2'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(v[6], 1'b1);
        $display("test opening done");
        final_report();
    end
endmodule : safe_lock_opening_timer_bench
